// [hdl/async_serial_pkg.sv]
// Constants for the asynchronous serial port: offsets, fields, resets and counts.
package async_serial_pkg;
	// ****************************************
	// Register map, byte addresses
	// ****************************************
	localparam logic [7:0] OFFSET_CONTROL = 8'h00;
	localparam logic [7:0] OFFSET_DATA = 8'h04;
	localparam logic [7:0] OFFSET_STATUS = 8'h08;
	localparam logic [7:0] OFFSET_MASK = 8'h0C;
	localparam int ADDR_WIDTH = 8;

	// ****************************************
	// Control register fields
	// ****************************************
	localparam int CTRL_FRAME_LENGTH_SELECT = 7;
	localparam int CTRL_MULTIPROC_CHECK_ENABLE = 5;
	localparam int CTRL_RECEIVE_ENABLE_BIT = 4;
	localparam int CTRL_TRANSMIT_NINTH_BIT = 3;
	localparam int CTRL_RECEIVED_NINTH_BIT = 2;
	localparam int CTRL_TRANSMIT_DONE_FLAG = 1;
	localparam int CTRL_RECEIVE_DONE_FLAG = 0;

	// ****************************************
	// Status and mask fields
	// ****************************************
	localparam int STAT_RECEIVE_DONE = 0;
	localparam int STAT_TRANSMIT_DONE = 1;
	localparam int STAT_TX_BUSY = 2;
	localparam int STAT_RX_BUSY = 3;
	localparam int FLAG_COUNT = 2;

	// ****************************************
	// Values after reset
	// ****************************************
	localparam logic [7:0] RESET_CONTROL = 8'h00;
	localparam logic [7:0] RESET_RX_BUFFER = 8'h00;
	localparam logic [1:0] RESET_FLAGS = 2'h0;
	localparam logic [1:0] RESET_MASK = 2'h0;

	// ****************************************
	// Bit timing in baud ticks
	// ****************************************
	localparam int OVERSAMPLE = 16;
	localparam logic [3:0] TICK_LAST = 4'(OVERSAMPLE - 1);
	localparam logic [3:0] TICK_HALF = 4'(OVERSAMPLE / 2 - 1);
	localparam logic [2:0] DATA_BIT_LAST = 3'h7;
endpackage : async_serial_pkg

// [hdl/serial_rx_if.sv]
// Connection between the port core and its receive engine.
`timescale 1ns/1ps
interface serial_rx_if;
	logic baudTick;
	logic serialIn;
	logic receiveEnable;
	logic nineBitMode;
	logic frameDone;
	logic [7:0] frameData;
	logic frameNinth;
	logic frameStop;
	logic busy;

	modport engine (
		input baudTick,
		input serialIn,
		input receiveEnable,
		input nineBitMode,
		output frameDone,
		output frameData,
		output frameNinth,
		output frameStop,
		output busy
	);
	modport core (
		output baudTick,
		output serialIn,
		output receiveEnable,
		output nineBitMode,
		input frameDone,
		input frameData,
		input frameNinth,
		input frameStop,
		input busy
	);
endinterface : serial_rx_if

// [hdl/serial_rx_engine.sv]
// Receive engine: start detection, mid-bit sampling and frame assembly.
`timescale 1ns/1ps
module serial_rx_engine (
	input wire logic clk,
	input wire logic reset,
	serial_rx_if.engine rx
);
	typedef enum logic [2:0] {
		RX_IDLE = 3'b000,
		RX_START = 3'b001,
		RX_DATA = 3'b010,
		RX_NINTH = 3'b011,
		RX_STOP = 3'b100
	} rx_state_t;

	rx_state_t state;
	rx_state_t next_state;
	logic [3:0] tickCount;
	logic [2:0] bitCount;
	logic [7:0] shiftReg;
	logic ninth;
	logic lineLast;
	logic doneReg;
	logic stopReg;

	// ****************************************
	// Decode
	// ****************************************
	wire startEdge = rx.receiveEnable && lineLast && !rx.serialIn;
	wire atHalf = rx.baudTick && (tickCount == async_serial_pkg::TICK_HALF);
	wire atSample = rx.baudTick && (tickCount == async_serial_pkg::TICK_LAST);
	wire lastData = bitCount == async_serial_pkg::DATA_BIT_LAST;

	always_comb begin
		next_state = state;
		unique case (state)
			RX_IDLE: if (startEdge) next_state = RX_START;
			// False starts shorter than half a bit are dropped
			RX_START: if (atHalf) next_state = rx.serialIn ? RX_IDLE : RX_DATA;
			RX_DATA: if (atSample && lastData) begin
				next_state = rx.nineBitMode ? RX_NINTH : RX_STOP;
			end
			RX_NINTH: if (atSample) next_state = RX_STOP;
			RX_STOP: if (atSample) next_state = RX_IDLE;
			default: next_state = RX_IDLE;
		endcase
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clk) begin
		if (reset) begin
			state <= RX_IDLE;
			lineLast <= 1'b1;
		end else begin
			state <= next_state;
			lineLast <= rx.serialIn;
		end
	end

	// Tick count restarts at mid start bit so later samples land mid-bit
	always_ff @(posedge clk) begin
		if (reset || state == RX_IDLE || (state == RX_START && atHalf)) begin
			tickCount <= 4'h0;
		end else if (rx.baudTick) begin
			tickCount <= tickCount + 4'h1;
		end
	end

	// Shift register is separate from the software buffer
	always_ff @(posedge clk) begin
		if (reset || state == RX_IDLE) begin
			bitCount <= 3'h0;
		end else if (state == RX_DATA && atSample) begin
			shiftReg <= {rx.serialIn, shiftReg[7:1]};
			bitCount <= bitCount + 3'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			ninth <= 1'b0;
		end else if (state == RX_NINTH && atSample) begin
			ninth <= rx.serialIn;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			doneReg <= 1'b0;
			stopReg <= 1'b1;
		end else begin
			doneReg <= state == RX_STOP && atSample;
			if (state == RX_STOP && atSample) stopReg <= rx.serialIn;
		end
	end

	assign rx.frameDone = doneReg;
	assign rx.frameData = shiftReg;
	assign rx.frameNinth = ninth;
	assign rx.frameStop = stopReg;
	assign rx.busy = state != RX_IDLE;
endmodule : serial_rx_engine

// [hdl/async_serial_port.sv]
// Asynchronous serial port: APB registers, transmitter, receive buffer and interrupt.
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
// Function
// - Full-duplex port; one control bit selects 8-bit or 9-bit frames.
// - 8-bit frame: low start bit, eight data bits, one stop bit.
// - Data bits go out and come in least significant first.
// - Writing a byte to the data buffer while the transmitter is idle starts a new frame.
// - Transmit-done sets when the stop bit period begins.
// - Frames are accepted only if receive enable is one at the start edge.
// - Load needs receive-done clear, and stop (ninth bit in 9-bit frames) one when checking enabled.
// - Load puts data in buffer, stop (ninth bit in 9-bit frames) in ninth field, sets receive-done.
// - Failed load leaves buffer, ninth field and receive-done untouched.
// - On overrun the first byte is kept; the later frame is lost.
// - Data address writes transmit register, reads receive buffer only.
// - Receiver assembles a second byte while the first awaits reading.
// - Enabled interrupt rises when either done flag becomes set.
// - An external timer overflow pulse is the bit-rate timebase.
module async_serial_port (
	input wire logic clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [async_serial_pkg::ADDR_WIDTH-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic baudTick,
	input wire logic serialIn,
	output logic serialOut,
	output logic irq
);
	typedef enum logic [2:0] {
		TX_IDLE = 3'b000,
		TX_START = 3'b001,
		TX_DATA = 3'b010,
		TX_NINTH = 3'b011,
		TX_STOP = 3'b100
	} tx_state_t;

	serial_rx_if rx ();

	logic frameLengthSelect;
	logic multiprocCheckEnable;
	logic receiveEnableBit;
	logic transmitNinthBit;
	logic receivedNinthBit;
	logic [7:0] serialDataBuffer;
	logic [async_serial_pkg::FLAG_COUNT-1:0] flags;
	logic [async_serial_pkg::FLAG_COUNT-1:0] mask;
	logic [async_serial_pkg::FLAG_COUNT-1:0] next_flags;
	tx_state_t txState;
	tx_state_t next_txState;
	logic [3:0] txTick;
	logic [2:0] txBit;
	logic [7:0] txShift;
	logic txNinth;
	logic txNine;
	logic next_serialOut;

	// ****************************************
	// APB decode
	// ****************************************
	wire accessPhase = psel && penable;
	wire transferDone = accessPhase && pready;
	wire writeDone = transferDone && pwrite;
	wire hitControl = paddr == async_serial_pkg::OFFSET_CONTROL;
	wire hitData = paddr == async_serial_pkg::OFFSET_DATA;
	wire hitStatus = paddr == async_serial_pkg::OFFSET_STATUS;
	wire hitMask = paddr == async_serial_pkg::OFFSET_MASK;
	wire mapped = hitControl || hitData || hitStatus || hitMask;
	wire controlWrite = writeDone && hitControl;
	wire dataWrite = writeDone && hitData;
	wire statusWrite = writeDone && hitStatus;
	wire maskWrite = writeDone && hitMask;

	wire transmitDoneFlag = flags[async_serial_pkg::STAT_TRANSMIT_DONE];
	wire receiveDoneFlag = flags[async_serial_pkg::STAT_RECEIVE_DONE];
	wire txBusy = txState != TX_IDLE;

	wire [7:0] controlView = {
		frameLengthSelect, 1'b0, multiprocCheckEnable, receiveEnableBit,
		transmitNinthBit, receivedNinthBit, transmitDoneFlag, receiveDoneFlag
	};
	wire [3:0] statusView = {rx.busy, txBusy, flags};

	// Transmit register has no read path
	wire [31:0] readMux =
		hitControl ? {24'h000000, controlView} :
		hitData ? {24'h000000, serialDataBuffer} :
		hitStatus ? {28'h0000000, statusView} :
		hitMask ? {30'h0, mask} : 32'h00000000;

	// One wait state: answer comes on the second access cycle
	always_ff @(posedge clk) begin
		if (reset) begin
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else begin
			pready <= accessPhase && !pready;
			if (accessPhase && !pready) begin
				prdata <= pwrite ? 32'h00000000 : readMux;
				pslverr <= !mapped;
			end
		end
	end

	// ****************************************
	// Control and mask registers
	// ****************************************
	always_ff @(posedge clk) begin
		if (reset) begin
			frameLengthSelect <= async_serial_pkg::RESET_CONTROL[async_serial_pkg::CTRL_FRAME_LENGTH_SELECT];
			multiprocCheckEnable <= async_serial_pkg::RESET_CONTROL[async_serial_pkg::CTRL_MULTIPROC_CHECK_ENABLE];
			receiveEnableBit <= async_serial_pkg::RESET_CONTROL[async_serial_pkg::CTRL_RECEIVE_ENABLE_BIT];
			transmitNinthBit <= async_serial_pkg::RESET_CONTROL[async_serial_pkg::CTRL_TRANSMIT_NINTH_BIT];
		end else if (controlWrite) begin
			frameLengthSelect <= pwdata[async_serial_pkg::CTRL_FRAME_LENGTH_SELECT];
			multiprocCheckEnable <= pwdata[async_serial_pkg::CTRL_MULTIPROC_CHECK_ENABLE];
			receiveEnableBit <= pwdata[async_serial_pkg::CTRL_RECEIVE_ENABLE_BIT];
			transmitNinthBit <= pwdata[async_serial_pkg::CTRL_TRANSMIT_NINTH_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			mask <= async_serial_pkg::RESET_MASK;
		end else if (maskWrite) begin
			mask <= pwdata[async_serial_pkg::FLAG_COUNT-1:0];
		end
	end

	// ****************************************
	// Transmitter
	// ****************************************
	wire txBitEnd = baudTick && (txTick == async_serial_pkg::TICK_LAST);
	wire txLastData = txBit == async_serial_pkg::DATA_BIT_LAST;
	// Stop bit begins here, so done is flagged now, not after the stop bit
	wire txDoneSet = txBitEnd && ((txState == TX_DATA && txLastData && !txNine)
		|| txState == TX_NINTH);

	// A write while a frame is in flight is dropped, never corrupts it
	always_comb begin
		next_txState = txState;
		next_serialOut = serialOut;
		unique case (txState)
			TX_IDLE: if (dataWrite) begin
				next_txState = TX_START;
				next_serialOut = 1'b0;
			end
			TX_START: if (txBitEnd) begin
				next_txState = TX_DATA;
				next_serialOut = txShift[0];
			end
			TX_DATA: if (txBitEnd) begin
				if (!txLastData) begin
					next_serialOut = txShift[1];
				end else if (txNine) begin
					next_txState = TX_NINTH;
					next_serialOut = txNinth;
				end else begin
					next_txState = TX_STOP;
					next_serialOut = 1'b1;
				end
			end
			TX_NINTH: if (txBitEnd) begin
				next_txState = TX_STOP;
				next_serialOut = 1'b1;
			end
			TX_STOP: if (txBitEnd) next_txState = TX_IDLE;
			default: begin
				next_txState = TX_IDLE;
				next_serialOut = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			txState <= TX_IDLE;
			serialOut <= 1'b1;
		end else begin
			txState <= next_txState;
			serialOut <= next_serialOut;
		end
	end

	always_ff @(posedge clk) begin
		if (reset || txState == TX_IDLE) begin
			txTick <= 4'h0;
		end else if (baudTick) begin
			txTick <= txTick + 4'h1;
		end
	end

	// Frame settings are frozen at the write so a mid-frame change is harmless
	always_ff @(posedge clk) begin
		if (reset) begin
			txShift <= 8'h00;
			txBit <= 3'h0;
			txNinth <= 1'b0;
			txNine <= 1'b0;
		end else if (txState == TX_IDLE && dataWrite) begin
			txShift <= pwdata[7:0];
			txBit <= 3'h0;
			txNinth <= transmitNinthBit;
			txNine <= frameLengthSelect;
		end else if (txState == TX_DATA && txBitEnd) begin
			txShift <= {1'b0, txShift[7:1]};
			txBit <= txBit + 3'h1;
		end
	end

	// ****************************************
	// Receiver and buffer
	// ****************************************
	assign rx.baudTick = baudTick;
	assign rx.serialIn = serialIn;
	assign rx.receiveEnable = receiveEnableBit;
	assign rx.nineBitMode = frameLengthSelect;

	serial_rx_engine rxEngine (
		.clk(clk),
		.reset(reset),
		.rx(rx.engine)
	);

	// In 9-bit frames the ninth bit takes the stop bit's place
	wire rxCheckBit = frameLengthSelect ? rx.frameNinth : rx.frameStop;
	wire rxLoad = rx.frameDone && !receiveDoneFlag
		&& (!multiprocCheckEnable || rxCheckBit);

	always_ff @(posedge clk) begin
		if (reset) begin
			serialDataBuffer <= async_serial_pkg::RESET_RX_BUFFER;
			receivedNinthBit <= 1'b0;
		end else if (rxLoad) begin
			serialDataBuffer <= rx.frameData;
			receivedNinthBit <= rxCheckBit;
		end
	end

	// ****************************************
	// Flags and interrupt
	// ****************************************
	// Only software clears; a set in the clearing cycle wins
	wire [async_serial_pkg::FLAG_COUNT-1:0] flagSet = {txDoneSet, rxLoad};
	wire [async_serial_pkg::FLAG_COUNT-1:0] flagClear =
		statusWrite ? pwdata[async_serial_pkg::FLAG_COUNT-1:0] : 2'h0;

	assign next_flags = (flags & ~flagClear) | flagSet;

	always_ff @(posedge clk) begin
		if (reset) begin
			flags <= async_serial_pkg::RESET_FLAGS;
			irq <= 1'b0;
		end else begin
			flags <= next_flags;
			irq <= |(next_flags & mask);
		end
	end
endmodule : async_serial_port

// [tb/async_serial_port_monitor.sv]
// Checker for the serial port ports.
`timescale 1ns/1ps
module async_serial_port_monitor (
	input wire logic clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [async_serial_pkg::ADDR_WIDTH-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic baudTick,
	input wire logic serialIn,
	input wire logic serialOut,
	input wire logic irq
);
	// ****************************************
	// Bus and line relations
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	wire logic commitWr = psel && penable && pready && pwrite;
	wire logic badAddr = paddr > async_serial_pkg::OFFSET_MASK || paddr[1:0] != 2'h0;
	a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
	a_ready_timing: assert property (psel && penable && !$past(penable) |=> pready)
		else $error("pready late");
	a_ready_access: assert property (pready |-> psel && penable) else $error("stray pready");
	a_err_decode: assert property (pready |-> pslverr == badAddr) else $error("bad pslverr");
	a_err_zero: assert property (pready && pslverr |-> prdata == 32'h0)
		else $error("error read not zero");
	a_write_zero: assert property (pready && pwrite |-> prdata == 32'h0)
		else $error("write read data not zero");
	// Line may only move on a tick, or start right after a data write
	a_line_timebase: assert property ($changed(serialOut) |-> $past(baudTick) || $past(commitWr))
		else $error("line moved off tick");
	a_irq_sticky: assert property ($fell(irq) |-> $past(commitWr))
		else $error("irq dropped without write");
endmodule : async_serial_port_monitor
bind async_serial_port async_serial_port_monitor mon (.clk(clk), .reset(reset), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .baudTick(baudTick), .serialIn(serialIn),
	.serialOut(serialOut), .irq(irq));

// [tb/serial_peer.sv]
// Remote transceiver model on the serial lines.
`timescale 1ns/1ps
module serial_peer (
	input wire logic clk,
	input wire logic baudTick,
	input wire logic lineIn,
	output logic lineOut
);
	// ****************************************
	// Frame send and capture, 16 ticks a bit
	// ****************************************
	logic nine = 1'b0;
	logic [9:0] got = 10'h000;
	int gotCount = 0;
	initial lineOut = 1'b1;
	// Idle level high between frames, like a pulled-up line
	task automatic send(input logic [7:0] data, input logic ninth, input logic stopBit);
		logic [10:0] frame;
		frame = nine ? {stopBit, ninth, data, 1'b0} : {1'b1, stopBit, data, 1'b0};
		for (int i = 0; i < (nine ? 11 : 10); i++) begin
			@(posedge clk iff baudTick);
			lineOut <= frame[i];
			repeat (15) @(posedge clk iff baudTick);
		end
		lineOut <= 1'b1;
	endtask : send
	// Mid-bit sampling; stop bit lands in got above the data
	initial begin
		forever begin
			@(negedge lineIn);
			repeat (8) @(posedge clk iff baudTick);
			for (int i = 0; i < (nine ? 10 : 9); i++) begin
				repeat (16) @(posedge clk iff baudTick);
				got[i] = lineIn;
			end
			gotCount++;
		end
	end
endmodule : serial_peer

// [tb/test_async_serial_port.sv]
// Bench for the serial port: APB tasks and frame scenarios.
`timescale 1ns/1ps
module test_async_serial_port;
	// ****************************************
	// Stimulus, tasks and sequence
	// ****************************************
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic baudTick = 1'b0;
	logic [31:0] prdata;
	logic pready, pslverr, serialIn, serialOut, irq, lastErr;
	int nMismatch = 0;
	int nTests = 0;
	localparam logic [7:0] CTL = async_serial_pkg::OFFSET_CONTROL;
	localparam logic [7:0] DAT = async_serial_pkg::OFFSET_DATA;
	localparam logic [7:0] STA = async_serial_pkg::OFFSET_STATUS;
	always #50 clk = ~clk;
	// Short tick period keeps each frame near 320 cycles
	always @(posedge clk) baudTick <= ~baudTick;
	async_serial_port uut (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .baudTick(baudTick), .serialIn(serialIn), .serialOut(serialOut),
		.irq(irq));
	serial_peer peer (.clk(clk), .baudTick(baudTick), .lineIn(serialOut), .lineOut(serialIn));
	task automatic test_done;
		$display("Counts: %0d compares, %0d mismatches", nTests, nMismatch);
		if (nMismatch == 0 && nTests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : test_done
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		nTests++;
		if (seen !== exp) begin
			nMismatch++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] rd);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		// Ready is taken at the rising edge, the same edge the write lands on
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) begin
			nMismatch++;
			test_done();
		end
		rd = prdata;
		lastErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] rd;
		apb(1'b1, a, d, rd);
	endtask : wr
	task automatic rdm(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
		logic [31:0] rd;
		apb(1'b0, a, 32'h0, rd);
		check(rd & m, exp);
	endtask : rdm
	task automatic waitIrq;
		int k;
		for (k = 0; k < 3000 && irq !== 1'b1; k++) @(negedge clk);
		if (k >= 3000) begin nMismatch++; test_done(); end
	endtask : waitIrq
	task automatic waitPeer(input int n);
		int k;
		for (k = 0; k < 3000 && peer.gotCount < n; k++) @(negedge clk);
		if (k >= 3000) begin nMismatch++; test_done(); end
	endtask : waitPeer
	initial begin
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		rdm(CTL, 32'h0, 32'hFFFFFFFF);
		rdm(STA, 32'h0, 32'hFFFFFFFF);
		rdm(8'h0C, 32'h0, 32'hFFFFFFFF);
		rdm(8'h10, 32'h0, 32'hFFFFFFFF);
		check(lastErr, 1'b1);
		wr(8'h10, 32'h3);
		check(lastErr, 1'b1);
		rdm(8'h0C, 32'h0, 32'hFFFFFFFF);
		$display("Test registers done");
		wr(8'h0C, 32'h3);
		wr(CTL, 32'h10);
		wr(DAT, 32'hA5);
		wr(DAT, 32'h3C);
		rdm(STA, 32'h4, 32'hF);
		waitIrq();
		check(peer.gotCount, 0);
		rdm(STA, 32'h2, 32'h3);
		waitPeer(1);
		check(peer.got[8:0], 9'h1A5);
		repeat (400) @(posedge clk);
		check(peer.gotCount, 1);
		rdm(STA, 32'h2, 32'h3);
		wr(STA, 32'h2);
		// Irq settles after the clearing edge
		@(negedge clk);
		check(irq, 1'b0);
		$display("Test transmit done");
		peer.send(8'h5A, 1'b0, 1'b1);
		waitIrq();
		rdm(DAT, 32'h5A, 32'hFFFFFFFF);
		rdm(CTL, 32'h15, 32'hFF);
		wr(STA, 32'h1);
		peer.send(8'h33, 1'b0, 1'b1);
		peer.send(8'h44, 1'b0, 1'b1);
		repeat (40) @(posedge clk);
		rdm(DAT, 32'h33, 32'hFFFFFFFF);
		rdm(STA, 32'h1, 32'h3);
		wr(STA, 32'h1);
		wr(CTL, 32'h30);
		peer.send(8'h99, 1'b0, 1'b0);
		repeat (40) @(posedge clk);
		rdm(STA, 32'h0, 32'h3);
		rdm(DAT, 32'h33, 32'hFFFFFFFF);
		$display("Test receive done");
		wr(CTL, 32'h98);
		peer.nine = 1'b1;
		wr(DAT, 32'hC3);
		waitPeer(2);
		check(peer.got, 10'h3C3);
		wr(STA, 32'h2);
		peer.send(8'h12, 1'b0, 1'b1);
		waitIrq();
		rdm(CTL, 32'h99, 32'hFF);
		rdm(DAT, 32'h12, 32'hFFFFFFFF);
		wr(STA, 32'h1);
		wr(CTL, 32'h00);
		peer.nine = 1'b0;
		peer.send(8'h55, 1'b0, 1'b1);
		repeat (40) @(posedge clk);
		rdm(STA, 32'h0, 32'h3);
		$display("Test modes done");
		test_done();
	end
endmodule : test_async_serial_port
